// ==== verilog/dcirq_pkg.sv ====
/*
 * Package for the DMA channel interrupt source block.
 * It holds the register map, the field layouts, the reset values and the
 * helper functions that the register slave uses; the channel takes only the count width and its reset value.
 * It assumes a 32-bit AXI4-Lite register bus and eight DMA channels.
 */
package dcirq_pkg;

  // Number of DMA channels and width of the programmed transfer count.
  localparam int unsigned DCIRQ_NUM_CH  = 8;
  localparam int unsigned DCIRQ_COUNT_W = 16;
  localparam int unsigned DCIRQ_ADDR_W  = 8;

  // Register byte offsets.
  localparam logic [7:0] DCIRQ_OFS_FLAGS  = 8'h00;  // end_flag / half_flag, write one to clear.
  localparam logic [7:0] DCIRQ_OFS_ENABLE = 8'h04;  // end_irq_enable / half_irq_enable.
  localparam logic [7:0] DCIRQ_OFS_REQ    = 8'h08;  // Live request lines, read only.
  localparam logic [7:0] DCIRQ_OFS_COUNT  = 8'h20;  // First channel count register.
  localparam logic [7:0] DCIRQ_OFS_STRIDE = 8'h04;  // Spacing of channel count registers.

  // Field positions shared by the flag, enable and request registers.
  localparam int unsigned DCIRQ_END_LSB  = 0;
  localparam int unsigned DCIRQ_HALF_LSB = 8;

  // Reset values.
  localparam logic [DCIRQ_COUNT_W-1:0] DCIRQ_COUNT_RST = 16'h0000;
  localparam logic [31:0]              DCIRQ_DATA_RST  = 32'h0000_0000;

  // AXI response codes.
  localparam logic [1:0] DCIRQ_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCIRQ_RESP_SLVERR = 2'h2;

  // Returns one when the address falls on a channel count register.
  function automatic logic dcirq_is_count(input logic [DCIRQ_ADDR_W-1:0] addr);
    logic [DCIRQ_ADDR_W-1:0] top_ofs;
    top_ofs = DCIRQ_OFS_COUNT + 8'(DCIRQ_NUM_CH * DCIRQ_OFS_STRIDE);
    return (addr >= DCIRQ_OFS_COUNT) && (addr < top_ofs) && (addr[1:0] == 2'h0);
  endfunction : dcirq_is_count

  // Returns the channel index of a count register address.
  function automatic logic [2:0] dcirq_count_ch(input logic [DCIRQ_ADDR_W-1:0] addr);
    logic [DCIRQ_ADDR_W-1:0] rel;
    rel = addr - DCIRQ_OFS_COUNT;
    return rel[4:2];
  endfunction : dcirq_count_ch

  // Merges new write data into an old value under the byte strobes.
  function automatic logic [31:0] dcirq_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : dcirq_merge

endpackage : dcirq_pkg

// ==== verilog/dcirq_channel.sv ====
/*
 * One DMA channel's transfer progress counter, its end and half flags,
 * its two interrupt enables and its two registered request lines.
 * It assumes the transfer engine pulses i_beat once per unit moved, and
 * that the register slave above it supplies one-cycle write strobes.
 */
`timescale 1ns/10ps
module dcirq_channel
  import dcirq_pkg::*;
#(
  parameter int unsigned COUNT_W = DCIRQ_COUNT_W
) (
  // Clock and reset.
  input  wire logic               i_clock,
  input  wire logic               i_reset,
  // Transfer progress from the engine.
  input  wire logic               i_beat,
  // Software writes.
  input  wire logic               i_load,
  input  wire logic [COUNT_W-1:0] i_load_count,
  input  wire logic               i_en_we,
  input  wire logic               i_en_end,
  input  wire logic               i_en_half,
  input  wire logic               i_clr_end,
  input  wire logic               i_clr_half,
  // State seen by software.
  output logic      [COUNT_W-1:0] o_remaining,
  output logic                    o_end_flag,
  output logic                    o_half_flag,
  output logic                    o_end_en,
  output logic                    o_half_en,
  // Request lines, registered and their next values.
  output logic                    o_end_req,
  output logic                    o_half_req,
  output logic                    o_end_req_nx,
  output logic                    o_half_req_nx
);

  logic [COUNT_W-1:0] remaining_q, remaining_d;  // Units still to move.
  logic [COUNT_W-1:0] total_q, total_d;          // Count as programmed.
  logic               end_flag_q, end_flag_d;    // Transfer end status.
  logic               half_flag_q, half_flag_d;  // Half end status.
  logic               end_en_q, end_en_d;        // end_irq_enable.
  logic               half_en_q, half_en_d;      // half_irq_enable.
  logic               end_req_q, half_req_q;     // Registered requests.
  logic               set_end, set_half;         // Flag set events.

  // Next-state logic: counting, flag setting and clearing, enables.
  always_comb begin
    remaining_d = remaining_q;
    total_d     = total_q;
    set_end     = 1'b0;
    set_half    = 1'b0;
    if (i_load) begin
      // A new count restarts the channel; a beat in this cycle is dropped.
      remaining_d = i_load_count;
      total_d     = i_load_count;
    end else if (i_beat && (remaining_q != '0)) begin
      remaining_d = remaining_q - 1'b1;
      // End on the last unit, half when half the count has moved.
      set_end  = (remaining_d == '0);
      set_half = (remaining_d == (total_q - (total_q >> 1))) && (total_q > 1);
    end
    // A set in the same cycle as a clear wins, so no event is lost.
    end_flag_d  = set_end  | (end_flag_q  & ~i_clr_end);
    half_flag_d = set_half | (half_flag_q & ~i_clr_half);
    end_en_d    = i_en_we ? i_en_end  : end_en_q;
    half_en_d   = i_en_we ? i_en_half : half_en_q;
    // Each request is its flag AND its enable; a cleared flag drops it.
    o_end_req_nx  = end_flag_d  & end_en_d;
    o_half_req_nx = half_flag_d & half_en_d;
  end

  // Registers for all channel state.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      remaining_q <= DCIRQ_COUNT_RST;
      total_q     <= DCIRQ_COUNT_RST;
      end_flag_q  <= 1'b0;
      half_flag_q <= 1'b0;
      end_en_q    <= 1'b0;
      half_en_q   <= 1'b0;
      end_req_q   <= 1'b0;
      half_req_q  <= 1'b0;
    end else begin
      remaining_q <= remaining_d;
      total_q     <= total_d;
      end_flag_q  <= end_flag_d;
      half_flag_q <= half_flag_d;
      end_en_q    <= end_en_d;
      half_en_q   <= half_en_d;
      end_req_q   <= o_end_req_nx;
      half_req_q  <= o_half_req_nx;
    end
  end

  // Drive the ports straight from the registers.
  assign o_remaining = remaining_q;
  assign o_end_flag  = end_flag_q;
  assign o_half_flag = half_flag_q;
  assign o_end_en    = end_en_q;
  assign o_half_en   = half_en_q;
  assign o_end_req   = end_req_q;
  assign o_half_req  = half_req_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // The end request mirrors flag and enable in every cycle.
  property p_end_req;
    o_end_req == (end_flag_q && end_en_q);
  endproperty
  a_end_req : assert property (p_end_req) else $error("end request not flag and enable");

  // The half request mirrors flag and enable in every cycle.
  property p_half_req;
    o_half_req == (half_flag_q && half_en_q);
  endproperty
  a_half_req : assert property (p_half_req) else $error("half request wrong");

  // Clearing the end flag withdraws the request at the next edge.
  property p_clear_drops;
    (o_end_req && i_clr_end && !set_end) |=> !o_end_req;
  endproperty
  a_clear_drops : assert property (p_clear_drops) else $error("request kept after clear");

  // Moving the last unit raises the end flag one edge later.
  property p_end_set;
    (i_beat && !i_load && remaining_q == COUNT_W'(1)) |=> (end_flag_q && remaining_q == '0);
  endproperty
  a_end_set : assert property (p_end_set) else $error("end flag not set at count end");

endmodule : dcirq_channel

// ==== verilog/dcirq_top.sv ====
/*
 * Interrupt request generation for an eight-channel DMA controller, with
 * an AXI4-Lite register slave for flags, enables and transfer counts.
 * It assumes one 10 MHz clock, an asynchronous active-high reset, a
 * transfer engine pulsing a beat per unit moved, and a system interrupt
 * controller that takes each request line on its own.
 */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
// Functional notes
// - Eight channels, each with end and half sources.
// - End request equals end flag AND enable.
// - Half request equals half flag AND enable.
// - Clearing flag drops request, no acknowledge.
// - Every request has its own output line.
// - Within a channel, end outranks half.
`timescale 1ns/10ps
module dcirq_top
  import dcirq_pkg::*;
#(
  parameter int unsigned COUNT_W = DCIRQ_COUNT_W
) (
  // Clock and reset.
  input  wire logic                    i_clock,
  input  wire logic                    i_reset,
  // AXI4-Lite write address and data.
  input  wire logic                    i_axi_awvalid,
  output logic                         o_axi_awready,
  input  wire logic [DCIRQ_ADDR_W-1:0] i_axi_awaddr,
  input  wire logic                    i_axi_wvalid,
  output logic                         o_axi_wready,
  input  wire logic [31:0]             i_axi_wdata,
  input  wire logic [3:0]              i_axi_wstrb,
  // AXI4-Lite write response.
  output logic                         o_axi_bvalid,
  input  wire logic                    i_axi_bready,
  output logic      [1:0]              o_axi_bresp,
  // AXI4-Lite read address and data.
  input  wire logic                    i_axi_arvalid,
  output logic                         o_axi_arready,
  input  wire logic [DCIRQ_ADDR_W-1:0] i_axi_araddr,
  output logic                         o_axi_rvalid,
  input  wire logic                    i_axi_rready,
  output logic      [31:0]             o_axi_rdata,
  output logic      [1:0]              o_axi_rresp,
  // Transfer progress, one pulse per unit per channel.
  input  wire logic [DCIRQ_NUM_CH-1:0] i_xfer_beat,
  // Request lines to the system interrupt controller.
  output logic      [DCIRQ_NUM_CH-1:0] o_xfer_end_irq,
  output logic      [DCIRQ_NUM_CH-1:0] o_xfer_half_irq,
  // Summary interrupt and highest pending source.
  output logic                         o_irq,
  output logic                         o_src_valid,
  output logic      [3:0]              o_src_code
);

  localparam int unsigned NCH = DCIRQ_NUM_CH;

  // Write channel state.
  logic                    aw_have_q, aw_have_d;   // Address held.
  logic [DCIRQ_ADDR_W-1:0] aw_addr_q, aw_addr_d;   // Held address.
  logic                    w_have_q, w_have_d;     // Data held.
  logic [31:0]             w_data_q, w_data_d;     // Held data.
  logic [3:0]              w_strb_q, w_strb_d;     // Held strobes.
  logic                    awready_q, awready_d;   // Address ready.
  logic                    wready_q, wready_d;     // Data ready.
  logic                    bvalid_q, bvalid_d;     // Response valid.
  logic [1:0]              bresp_q, bresp_d;       // Response code.
  logic                    do_write;               // Write performed now.
  // Read channel state.
  logic                    arready_q, arready_d;   // Read address ready.
  logic                    rvalid_q, rvalid_d;     // Read data valid.
  logic [31:0]             rdata_q, rdata_d;       // Read data.
  logic [1:0]              rresp_q, rresp_d;       // Read response.
  // Channel strobes and state.
  logic [NCH-1:0]          ch_load, ch_clr_end, ch_clr_half;
  logic                    en_we;                  // Enable register write.
  logic [31:0]             wr_merged;              // Strobed write value.
  logic [COUNT_W-1:0]      remaining [NCH];        // Counts left per channel.
  logic [NCH-1:0]          end_flag, half_flag, end_en, half_en;
  logic [NCH-1:0]          end_req, half_req, end_req_nx, half_req_nx;
  // Summary outputs.
  logic                    irq_q, irq_d;
  logic                    src_valid_q, src_valid_d;
  logic [3:0]              src_code_q, src_code_d;

  // One channel unit per DMA channel, each with its own pair of lines.
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    dcirq_channel #(.COUNT_W(COUNT_W)) u_ch (
      .i_clock       (i_clock),
      .i_reset       (i_reset),
      .i_beat        (i_xfer_beat[c]),
      .i_load        (ch_load[c]),
      .i_load_count  (wr_merged[COUNT_W-1:0]),
      .i_en_we       (en_we),
      .i_en_end      (wr_merged[DCIRQ_END_LSB + c]),
      .i_en_half     (wr_merged[DCIRQ_HALF_LSB + c]),
      .i_clr_end     (ch_clr_end[c]),
      .i_clr_half    (ch_clr_half[c]),
      .o_remaining   (remaining[c]),
      .o_end_flag    (end_flag[c]),
      .o_half_flag   (half_flag[c]),
      .o_end_en      (end_en[c]),
      .o_half_en     (half_en[c]),
      .o_end_req     (end_req[c]),
      .o_half_req    (half_req[c]),
      .o_end_req_nx  (end_req_nx[c]),
      .o_half_req_nx (half_req_nx[c])
    );
  end

  // Write path: take address and data in either order, then answer.
  always_comb begin
    aw_have_d   = aw_have_q;
    aw_addr_d   = aw_addr_q;
    w_have_d    = w_have_q;
    w_data_d    = w_data_q;
    w_strb_d    = w_strb_q;
    bvalid_d    = bvalid_q;
    bresp_d     = bresp_q;
    ch_load     = '0;
    ch_clr_end  = '0;
    ch_clr_half = '0;
    en_we       = 1'b0;
    do_write    = aw_have_q && w_have_q && !bvalid_q;
    wr_merged   = DCIRQ_DATA_RST;
    if (i_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_axi_awaddr;
    end
    if (i_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = i_axi_wdata;
      w_strb_d = i_axi_wstrb;
    end
    if (bvalid_q && i_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = DCIRQ_RESP_OKAY;
      if (aw_addr_q == DCIRQ_OFS_FLAGS) begin
        // Writing one clears a flag, which withdraws its request.
        wr_merged   = dcirq_merge(DCIRQ_DATA_RST, w_data_q, w_strb_q);
        ch_clr_end  = wr_merged[DCIRQ_END_LSB +: NCH];
        ch_clr_half = wr_merged[DCIRQ_HALF_LSB +: NCH];
      end else if (aw_addr_q == DCIRQ_OFS_ENABLE) begin
        wr_merged = dcirq_merge({16'h0000, half_en, end_en}, w_data_q, w_strb_q);
        en_we     = 1'b1;
      end else if (aw_addr_q == DCIRQ_OFS_REQ) begin
        bresp_d = DCIRQ_RESP_OKAY;
      end else if (dcirq_is_count(aw_addr_q)) begin
        wr_merged = dcirq_merge(32'(remaining[dcirq_count_ch(aw_addr_q)]), w_data_q, w_strb_q);
        ch_load[dcirq_count_ch(aw_addr_q)] = 1'b1;
      end else begin
        bresp_d = DCIRQ_RESP_SLVERR;
      end
    end
    // Ready only while nothing is held and no response waits.
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  // Read path: one read at a time, data from a register.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && i_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = DCIRQ_RESP_OKAY;
      if (i_axi_araddr == DCIRQ_OFS_FLAGS) begin
        rdata_d = {16'h0000, half_flag, end_flag};
      end else if (i_axi_araddr == DCIRQ_OFS_ENABLE) begin
        rdata_d = {16'h0000, half_en, end_en};
      end else if (i_axi_araddr == DCIRQ_OFS_REQ) begin
        rdata_d = {16'h0000, half_req, end_req};
      end else if (dcirq_is_count(i_axi_araddr)) begin
        rdata_d = 32'(remaining[dcirq_count_ch(i_axi_araddr)]);
      end else begin
        rdata_d = DCIRQ_DATA_RST;
        rresp_d = DCIRQ_RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  // Summary: any request raises the interrupt; the pending source shown
  // is the lowest channel, and its end source before its half source.
  always_comb begin
    irq_d       = |{end_req_nx, half_req_nx};
    src_valid_d = 1'b0;
    src_code_d  = 4'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (end_req_nx[c]) begin
        src_valid_d = 1'b1;
        src_code_d  = {3'(c), 1'b0};  // End ranks above half.
      end else if (half_req_nx[c]) begin
        src_valid_d = 1'b1;
        src_code_d  = {3'(c), 1'b1};
      end
    end
  end

  // Registers of the bus slave and the summary outputs.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      aw_have_q   <= 1'b0;
      aw_addr_q   <= '0;
      w_have_q    <= 1'b0;
      w_data_q    <= DCIRQ_DATA_RST;
      w_strb_q    <= 4'h0;
      awready_q   <= 1'b0;
      wready_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= DCIRQ_RESP_OKAY;
      arready_q   <= 1'b0;
      rvalid_q    <= 1'b0;
      rdata_q     <= DCIRQ_DATA_RST;
      rresp_q     <= DCIRQ_RESP_OKAY;
      irq_q       <= 1'b0;
      src_valid_q <= 1'b0;
      src_code_q  <= 4'h0;
    end else begin
      aw_have_q   <= aw_have_d;
      aw_addr_q   <= aw_addr_d;
      w_have_q    <= w_have_d;
      w_data_q    <= w_data_d;
      w_strb_q    <= w_strb_d;
      awready_q   <= awready_d;
      wready_q    <= wready_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      arready_q   <= arready_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      irq_q       <= irq_d;
      src_valid_q <= src_valid_d;
      src_code_q  <= src_code_d;
    end
  end

  // Port drive, all from registers.
  assign o_axi_awready   = awready_q;
  assign o_axi_wready    = wready_q;
  assign o_axi_bvalid    = bvalid_q;
  assign o_axi_bresp     = bresp_q;
  assign o_axi_arready   = arready_q;
  assign o_axi_rvalid    = rvalid_q;
  assign o_axi_rdata     = rdata_q;
  assign o_axi_rresp     = rresp_q;
  assign o_xfer_end_irq  = end_req;
  assign o_xfer_half_irq = half_req;
  assign o_irq           = irq_q;
  assign o_src_valid     = src_valid_q;
  assign o_src_code      = src_code_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // The summary is high exactly while any of the sixteen lines is high.
  property p_src_count;
    o_src_valid == (|{o_xfer_end_irq, o_xfer_half_irq});
  endproperty
  a_src_count : assert property (p_src_count) else $error("source valid mismatch");

  // The summary interrupt tracks the separate lines in the same cycle.
  property p_irq_lines;
    o_irq == ((o_xfer_end_irq != '0) || (o_xfer_half_irq != '0));
  endproperty
  a_irq_lines : assert property (p_irq_lines) else $error("irq not tied to lines");

  // A half source is never shown while the same channel has an end request.
  property p_end_first;
    (o_src_valid && o_src_code[0]) |-> !o_xfer_end_irq[o_src_code[3:1]];
  endproperty
  a_end_first : assert property (p_end_first) else $error("half shown over end");

  // A performed write is answered at the next edge, with both readies low.
  property p_write_answer;
    do_write |=> (o_axi_bvalid && !o_axi_awready && !o_axi_wready);
  endproperty
  a_write_answer : assert property (p_write_answer) else $error("write answer late");

endmodule : dcirq_top

// ==== test/dcirq_system_irq_controller_model.sv ====
/*
 * Behavioural model of the system interrupt controller at the far side.
 * It assumes sixteen separate level request lines from the DMA block.
 */
`timescale 1ns/10ps
module dcirq_irq_ctrl_model (
  // Request lines from the DMA block.
  input  wire logic [7:0] i_end_req,
  input  wire logic [7:0] i_half_req,
  // Source that the controller would serve first.
  output logic            o_pend,
  output logic      [3:0] o_code
);
  // Scan from the lowest rank up so that channel 0 and its end source win last.
  always_comb begin
    o_pend = 1'b0;
    o_code = 4'h0;
    for (int c = 7; c >= 0; c--) begin
      if (i_half_req[c]) begin
        o_pend = 1'b1;
        o_code = {3'(c), 1'b1};
      end
      if (i_end_req[c]) begin
        o_pend = 1'b1;
        o_code = {3'(c), 1'b0};
      end
    end
  end
endmodule : dcirq_irq_ctrl_model

// ==== test/dcirq_top_test.sv ====
/*
 * Self-checking bench for the DMA channel interrupt source block.
 * It assumes the register map and bus timing of the block's register slave.
 */
`timescale 1ns/10ps
module dcirq_top_test;
  import dcirq_pkg::*;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
  // Clock, reset and bus master signals.
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, beat = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  end_irq, half_irq, m;
  logic        irq, src_valid, pend;
  logic [3:0]  src_code, code;
  int          errors = 0, num_checks = 0;

  // The clock toggles every half period of 50 ns.
  always #50 clock = ~clock;

  dcirq_top i_dcirq_top (.i_clock(clock), .i_reset(reset), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid),
    .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .o_axi_bvalid(bvalid),
    .i_axi_bready(bready), .o_axi_bresp(bresp), .i_axi_arvalid(arvalid),
    .o_axi_arready(arready), .i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_xfer_beat(beat),
    .o_xfer_end_irq(end_irq), .o_xfer_half_irq(half_irq), .o_irq(irq),
    .o_src_valid(src_valid), .o_src_code(src_code));
  dcirq_irq_ctrl_model i_dcirq_irq_ctrl_model (.i_end_req(end_irq), .i_half_req(half_irq),
    .o_pend(pend), .o_code(code));

  // Write one word; readies are sampled at the falling edge, handshakes land at the rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
    while (!b_hs) begin
      @(negedge clock);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bready && bvalid;
      resp  = bresp;
      @(posedge clock);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
  endtask : wr

  // Read one word into o_d, with its response code left in resp.
  task automatic rd(input logic [7:0] a, output logic [31:0] o_d);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!r_hs) begin
      @(negedge clock);
      ar_hs = arvalid && arready;
      r_hs  = rready && rvalid;
      o_d   = rdata;
      resp  = rresp;
      @(posedge clock);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
  endtask : rd

  // Pulse n beats on one channel, then let the final edge settle.
  task automatic beats(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock); beat <= 8'h01 << ch;
      @(posedge clock); beat <= 8'h00;
    end
    #1;
  endtask : beats

  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Cut a hang short well past the expected run length.
  initial begin
    #(100 * 20000);
    errors++;
    conclude();
  end

  // Main sequence of tests.
  initial begin
    logic [31:0] v;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    rd(DCIRQ_OFS_FLAGS, v);  `CHK("flags", 32'h0, v)
    rd(DCIRQ_OFS_ENABLE, v); `CHK("enable", 32'h0, v)
    rd(8'h10, v);  `CHK("unmapped resp", DCIRQ_RESP_SLVERR, resp)
    `CHK("unmapped data", 32'h0, v)
    `CHK("src idle at start", 1'b0, src_valid)
    $display("test reset done");
    // Each channel: half point, end point, then clear end and half separately.
    for (int n = 0; n < 8; n++) begin
      m = 8'h01 << n;
      wr(DCIRQ_OFS_COUNT + 8'(4 * n), 32'h4, 4'hf);
      wr(DCIRQ_OFS_ENABLE, {16'h0, m, m}, 4'hf);
      beats(n, 2);
      `CHK("half req", m, half_irq)
      `CHK("end req early", 8'h00, end_irq)
      `CHK("code half", {3'(n), 1'b1}, src_code)
      `CHK("src valid", 1'b1, src_valid)
      `CHK("model pend", 1'b1, pend)
      beats(n, 2);
      `CHK("end req", m, end_irq)
      `CHK("code end", {3'(n), 1'b0}, src_code)
      `CHK("model code", {3'(n), 1'b0}, code)
      rd(DCIRQ_OFS_REQ, v); `CHK("req reg", {16'h0, m, m}, v)
      wr(DCIRQ_OFS_FLAGS, {24'h0, m}, 4'hf); #1;
      `CHK("end cleared", 8'h00, end_irq)
      `CHK("half kept", m, half_irq)
      wr(DCIRQ_OFS_FLAGS, {16'h0, m, 8'h00}, 4'hf); #1;
      `CHK("irq cleared", 1'b0, irq)
      `CHK("src cleared", 1'b0, src_valid)
      `CHK("model idle", 1'b0, pend)
    end
    $display("test channels done");
    // Masked end source on channel 3, count of one gives no half flag.
    wr(DCIRQ_OFS_ENABLE, 32'h0, 4'hf);
    wr(DCIRQ_OFS_COUNT + 8'hc, 32'h1, 4'hf);
    beats(3, 1);
    rd(DCIRQ_OFS_FLAGS, v); `CHK("flag masked", 32'h8, v)
    `CHK("masked req", 8'h00, end_irq)
    `CHK("masked irq", 1'b0, irq)
    wr(DCIRQ_OFS_ENABLE, 32'hffff_ffff, 4'h1); #1;
    `CHK("unmasked req", 8'h08, end_irq)
    `CHK("half en off", 8'h00, half_irq)
    // Channel 5 half against channel 3 end.
    wr(DCIRQ_OFS_COUNT + 8'h14, 32'h2, 4'hf);
    beats(5, 1);
    `CHK("no half en", 8'h00, half_irq)
    wr(DCIRQ_OFS_ENABLE, 32'hffff_ffff, 4'h2); #1;
    `CHK("half on", 8'h20, half_irq)
    `CHK("prio code", 4'h6, src_code)
    `CHK("prio model", 4'h6, code)
    rd(DCIRQ_OFS_COUNT + 8'h14, v); `CHK("count left", 32'h1, v)
    wr(DCIRQ_OFS_REQ, 32'h0, 4'hf); `CHK("req wr resp", DCIRQ_RESP_OKAY, resp)
    wr(8'h10, 32'hffff_ffff, 4'hf); `CHK("unmapped wr resp", DCIRQ_RESP_SLVERR, resp)
    `CHK("unmapped wr kept", 8'h08, end_irq)
    `CHK("req wr kept", 8'h08, end_irq)
    wr(DCIRQ_OFS_FLAGS, 32'h8, 4'hf); #1;
    `CHK("next code", 4'hb, src_code)
    `CHK("next model", 4'hb, code)
    `CHK("irq left", 1'b1, irq)
    $display("test mask and priority done");
    conclude();
  end
endmodule : dcirq_top_test
